/* src/rlsd_top.sv */
// Behaviour
// R1 - serial bits are distributed round-robin over four lanes
// R2 - lane 3 carries earliest bit of each quartet, lane 0 latest
// R3 - quartet alignment to the serial stream is arbitrary
// R4 - nibble-aligned input puts first nibble bit on lane 3
// R5 - each lane carries one bit of every four, quarter rate
// R6 - optional inversion of all lanes for five samples in odd half-frame
// R7 - reference lane repeats 4 samples, odd parity, 4 samples, even parity
// R8 - reference samples taken lane 3 down to lane 0
// R9 - reference samples are taken after inversion
// R10 - timing reference is 50% duty at 1/16 of lane bit rate
// R11 - timing reference paces lane and reference lane generation
// R12 - this source implements the timing reference output
// R13 - alarm status line low idle, high alarm
// R14 - alarm raised when lane data not derived from input signal
// R15 - the alarm status line is always generated
// R16 - sink may ignore the alarm status line
// R17 - sink treats the alarm status as asynchronous
// R18 - sink compares reference samples with lane bits to measure skew
// R19 - reference lane runs continuously at full lane rate; code pauses lane and reference ticks while the FIFO is empty and alarm is low
// R20 - alternating parity guarantees a transition every ten bits
// R21 - odd parity makes ones count odd, even parity makes it even
// R22 - one clock domain, a configuration bit selects inversion
`timescale 1ns/10ps

module rlsd_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] wp_nxt;
    logic [AW:0] rp_r;
    logic [AW:0] rp_nxt;
    logic full;
    logic empty;

    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty = (wp_r == rp_r);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rp_r[AW-1:0]];

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (in_valid && !full) begin
            wp_nxt = wp_r + 1'b1;
        end
        if (out_ready && !empty) begin
            rp_nxt = rp_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

module rlsd_top
    import rlsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rx_ser_clk,
    input wire logic rx_ser_data,
    input wire logic rx_sig_lost,
    input wire logic inv_en,
    output logic [LANES-1:0] rx_lane_data,
    output logic rx_skew_ref_lane,
    output logic rx_timing_ref,
    output logic rx_alarm_status,
    output logic rx_lane_strobe
);
    // input synchronisers; stage 0 feeds stage 1 only
    logic [2:0] sclk_r;
    logic [1:0] sdat_r;
    logic [1:0] slos_r;
    logic bit_edge;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_r <= '0;
            sdat_r <= '0;
            slos_r <= 2'h3;
        end else begin
            sclk_r <= {sclk_r[1:0], rx_ser_clk};
            sdat_r <= {sdat_r[0], rx_ser_data};
            slos_r <= {slos_r[0], rx_sig_lost};
        end
    end

    assign bit_edge = sclk_r[1] && !sclk_r[2];

    // quartet gathering
    rlsd_word_t shreg_r;
    rlsd_word_t shreg_nxt;
    logic [1:0] qcnt_r;
    logic [1:0] qcnt_nxt;
    logic push_r;
    logic push_nxt;
    rlsd_word_t word_r;
    rlsd_word_t word_nxt;

    always_comb begin
        shreg_nxt = shreg_r;
        qcnt_nxt = qcnt_r;
        push_nxt = 1'b0;
        word_nxt = word_r;
        if (bit_edge) begin
            // R1 R2 R4 round-robin, first bit ends on lane 3
            shreg_nxt = {shreg_r[2:0], sdat_r[1]};
            qcnt_nxt = qcnt_r + 2'h1;
            // R3 R5 one word per four bits, alignment free-running
            if (qcnt_r == QUARTET_LAST) begin
                push_nxt = 1'b1;
                word_nxt = shreg_nxt;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg_r <= WORD_ZERO;
            qcnt_r <= '0;
            push_r <= 1'b0;
            word_r <= WORD_ZERO;
        end else begin
            shreg_r <= shreg_nxt;
            qcnt_r <= qcnt_nxt;
            push_r <= push_nxt;
            word_r <= word_nxt;
        end
    end

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic gap_done;
    rlsd_word_t fifo_data;

    rlsd_fifo #(
        .WIDTH(LANES),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .in_data(word_r),
        .out_valid(fifo_out_valid),
        .out_ready(gap_done),
        .out_data(fifo_data)
    );

    // alarm: loss input, stalled serial clock, or overrun
    logic [6:0] idle_r;
    logic [6:0] idle_nxt;
    logic alarm_r;
    logic alarm_nxt;

    always_comb begin
        idle_nxt = idle_r;
        if (bit_edge) begin
            idle_nxt = '0;
        end else if (idle_r != IDLE_LAST) begin
            idle_nxt = idle_r + 7'h1;
        end
        // R14 R15 alarm whenever lanes not fed by the input
        alarm_nxt = slos_r[1] || (idle_r == IDLE_LAST) || (push_r && !fifo_in_ready);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_r <= '0;
            alarm_r <= 1'b1;
        end else begin
            idle_r <= idle_nxt;
            alarm_r <= alarm_nxt;
        end
    end

    // lane pacing, frame and reference generation
    logic [5:0] gap_r;
    logic [5:0] gap_nxt;
    logic tick;
    logic [3:0] pos_r;
    logic [3:0] pos_nxt;
    logic par_r;
    logic par_nxt;
    logic [2:0] rc_r;
    logic [2:0] rc_nxt;
    rlsd_out_t out_r;
    rlsd_out_t out_nxt;
    logic [3:0] opos_r;
    logic [3:0] opos_nxt;
    rlsd_word_t lane;
    logic [1:0] sidx;
    logic sample;

    assign gap_done = (gap_r == GAP_LAST);
    // R11 R19 lane ticks continue from local pacing during alarm
    assign tick = gap_done && (alarm_r || fifo_out_valid);

    always_comb begin
        gap_nxt = gap_r;
        pos_nxt = pos_r;
        par_nxt = par_r;
        rc_nxt = rc_r;
        opos_nxt = opos_r;
        out_nxt = out_r;
        out_nxt.strobe = 1'b0;
        // R13 one-bit status, high is alarm
        out_nxt.alarm = alarm_r;
        lane = alarm_r ? WORD_ZERO : fifo_data;
        // R6 R22 invert during the odd half when enabled
        if (inv_en && (pos_r >= HALF_START)) begin
            lane = ~lane;
        end
        sidx = (pos_r < POS_ODD_PAR) ? 2'(QUARTET_LAST - pos_r[1:0]) : 2'(HALF1_TOP - pos_r);
        // R8 R9 sample the transmitted, inverted value
        sample = lane[sidx];
        if (!gap_done) begin
            gap_nxt = gap_r + 6'h1;
        end
        if (tick) begin
            gap_nxt = '0;
            out_nxt.strobe = 1'b1;
            out_nxt.data = lane;
            opos_nxt = pos_r;
            pos_nxt = (pos_r == FRAME_LAST) ? POS_FIRST : pos_r + 4'h1;
            // R7 R20 R21 samples then alternating parity bits
            if (pos_r == POS_ODD_PAR) begin
                out_nxt.skew_ref = ~par_r;
            end else if (pos_r == POS_EVEN_PAR) begin
                out_nxt.skew_ref = par_r;
            end else begin
                out_nxt.skew_ref = sample;
                par_nxt = (pos_r == POS_FIRST || pos_r == HALF_START) ? sample : par_r ^ sample;
            end
            // R10 R12 toggle every eight lane bits
            rc_nxt = rc_r + 3'h1;
            if (rc_r == REF_HALF_LAST) begin
                out_nxt.timing_ref = ~out_r.timing_ref;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_r <= '0;
            pos_r <= POS_FIRST;
            par_r <= 1'b0;
            rc_r <= '0;
            opos_r <= POS_FIRST;
            out_r <= OUT_RESET;
        end else begin
            gap_r <= gap_nxt;
            pos_r <= pos_nxt;
            par_r <= par_nxt;
            rc_r <= rc_nxt;
            opos_r <= opos_nxt;
            out_r <= out_nxt;
        end
    end

    assign rx_lane_data = out_r.data;
    assign rx_skew_ref_lane = out_r.skew_ref;
    assign rx_timing_ref = out_r.timing_ref;
    assign rx_alarm_status = out_r.alarm;
    assign rx_lane_strobe = out_r.strobe;
    // checking helpers
    logic [9:0] hist_r;
    logic tref_d_r;
    logic [3:0] tk_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_r <= '0;
            tref_d_r <= 1'b0;
            tk_r <= '0;
        end else begin
            if (out_r.strobe) begin
                hist_r <= {hist_r[8:0], out_r.skew_ref};
            end
            tref_d_r <= out_r.timing_ref;
            if (out_r.timing_ref != tref_d_r) begin
                tk_r <= '0;
            end else if (out_r.strobe) begin
                tk_r <= tk_r + 4'h1;
            end
        end
    end

    a_strobe_spacing: assert property (@(posedge clk) disable iff (!rst_n) // R19
        out_r.strobe |=> !out_r.strobe [*8]) else $error("lane strobes too close");
    a_odd_parity: assert property (@(posedge clk) disable iff (!rst_n) // R21
        out_r.strobe && opos_r == POS_ODD_PAR |=> ^hist_r[4:0]) else $error("odd parity wrong");
    a_even_parity: assert property (@(posedge clk) disable iff (!rst_n) // R7
        out_r.strobe && opos_r == POS_EVEN_PAR |=> !(^hist_r[4:0])) else $error("even parity wrong");
    a_sample_lane: assert property (@(posedge clk) disable iff (!rst_n) // R8
        out_r.strobe && opos_r < POS_ODD_PAR |-> out_r.skew_ref == out_r.data[2'(QUARTET_LAST - opos_r[1:0])])
        else $error("reference sample mismatch");
    // loss flop, then alarm flop, then output flop
    a_alarm_loss: assert property (@(posedge clk) disable iff (!rst_n) // R14
        slos_r[1] |-> ##2 out_r.alarm) else $error("alarm missing on signal loss");
    a_ref_on_tick: assert property (@(posedge clk) disable iff (!rst_n) // R10
        $changed(out_r.timing_ref) |-> out_r.strobe) else $error("timing reference moved off a tick");
    a_ref_duty: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (out_r.timing_ref != tref_d_r) |-> tk_r == 4'(REF_HALF_LAST)) else $error("timing reference half period wrong");
    a_word_push: assert property (@(posedge clk) disable iff (!rst_n) // R5
        bit_edge && qcnt_r == QUARTET_LAST |=> push_r ##1 !push_r) else $error("quartet not pushed");
    a_inv_alarm: assert property (@(posedge clk) disable iff (!rst_n) // R6
        out_r.strobe && out_r.alarm && $past(alarm_r, 2) && $past(inv_en) && opos_r >= HALF_START
        |-> out_r.data == ~WORD_ZERO) else $error("odd half not inverted");
endmodule

/* src/rlsd_pkg.sv */
package rlsd_pkg;

    localparam int LANES = 4;
    localparam int FIFO_DEPTH = 4;

    // reference frame positions
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [3:0] POS_ODD_PAR = 4'h4;
    localparam logic [3:0] POS_EVEN_PAR = 4'h9;
    localparam logic [3:0] HALF_START = 4'h5;
    localparam logic [3:0] HALF1_TOP = 4'h8;
    localparam logic [1:0] QUARTET_LAST = 2'h3;
    localparam logic [3:0] POS_FIRST = 4'h0;

    // timing reference toggles every eight lane bits
    localparam logic [2:0] REF_HALF_LAST = 3'h7;

    localparam int CLK_MHZ = 100;
    localparam int CLK_LOSS_NS = 1000;
    localparam int CLK_LOSS_CYC = CLK_LOSS_NS * CLK_MHZ / 1000;
    localparam int LANE_GAP_NS = 400;
    localparam int LANE_GAP_CYC = (LANE_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [6:0] IDLE_LAST = 7'(CLK_LOSS_CYC - 1);
    localparam logic [5:0] GAP_LAST = 6'(LANE_GAP_CYC - 1);

    typedef logic [LANES-1:0] rlsd_word_t;

    typedef struct packed {
        rlsd_word_t data;
        logic skew_ref;
        logic timing_ref;
        logic alarm;
        logic strobe;
    } rlsd_out_t;

    localparam rlsd_out_t OUT_RESET = '0;
    localparam rlsd_word_t WORD_ZERO = 4'h0;

endpackage

/* sim/rlsd_sink_model.sv */
`timescale 1ns/10ps

module rlsd_sink_model
    import rlsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire rlsd_out_t pins,
    output rlsd_out_t cap,
    output logic cap_valid,
    output logic alarm_sync
);
    logic [1:0] sync_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= 2'h0;
            cap <= OUT_RESET;
            cap_valid <= 1'b0;
        end else begin
            sync_r <= {sync_r[0], pins.alarm};
            cap_valid <= pins.strobe;
            if (pins.strobe) begin
                cap <= pins;
            end
        end
    end

    assign alarm_sync = sync_r[1];
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps

module tb_top
    import rlsd_pkg::*;
;
    logic clk;
    logic rst_n;
    logic ser_clk;
    logic ser_data;
    logic sig_lost;
    logic inv_en;
    logic [LANES-1:0] lane_data;
    logic skew_ref;
    logic timing_ref;
    logic alarm_status;
    logic lane_strobe;
    rlsd_out_t pins;
    rlsd_out_t cap;
    logic cap_valid;
    logic alarm_sync;
    int failures = 0;
    int total_checks = 0;
    int scnt = 0;
    int run = 0;
    logic par = 1'b0;
    logic last_ref = 1'b0;
    rlsd_word_t exp_q[$];

    rlsd_top i_rlsd_top (
        .clk(clk), .rst_n(rst_n), .rx_ser_clk(ser_clk), .rx_ser_data(ser_data), .rx_sig_lost(sig_lost),
        .inv_en(inv_en), .rx_lane_data(lane_data), .rx_skew_ref_lane(skew_ref), .rx_timing_ref(timing_ref),
        .rx_alarm_status(alarm_status), .rx_lane_strobe(lane_strobe)
    );

    assign pins = {lane_data, skew_ref, timing_ref, alarm_status, lane_strobe};

    rlsd_sink_model i_rlsd_sink_model (
        .clk(clk), .rst_n(rst_n), .pins(pins), .cap(cap), .cap_valid(cap_valid), .alarm_sync(alarm_sync)
    );

    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_alarm(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && alarm_sync !== lvl; i++) begin
            @(posedge clk);
        end
        if (alarm_sync !== lvl) begin
            failures++;
            finish_test();
        end
        check("alarm", 8'(alarm_status), 8'(lvl));
    endtask

    task automatic wait_cap();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (cap_valid !== 1'b1 && i < 100);
        if (cap_valid !== 1'b1) begin
            failures++;
            finish_test();
        end
        #1;
    endtask

    // serial bit clock runs only while a word is sent
    task automatic send_word(input rlsd_word_t w);
        for (int i = LANES - 1; i >= 0; i--) begin
            #62.5 ser_clk = 1'b0;
            ser_data = w[i];
            #62.5 ser_clk = 1'b1;
        end
        exp_q.push_back(w);
    endtask

    task automatic send_rand(input int n);
        repeat (n) send_word(rlsd_word_t'($urandom));
    endtask

    task automatic drain();
        for (int i = 0; i < 300 && exp_q.size() > 0; i++) begin
            @(posedge clk);
        end
        if (exp_q.size() > 0) begin
            failures++;
            finish_test();
        end
        #1;
    endtask

    always @(posedge clk) begin
        int pos;
        logic [3:0] flip;
        if (cap_valid) begin
            pos = scnt % 10;
            scnt++;
            flip = (inv_en && pos >= 5) ? 4'hf : 4'h0;
            if (cap.alarm) begin
                check("alarm_lanes", 8'(cap.data), 8'(flip));
            end else if (exp_q.size() > 0) begin
                check("lanes", 8'(cap.data), 8'(exp_q.pop_front() ^ flip));
            end
            if (pos % 5 == 4) begin
                check("parity", 8'(cap.skew_ref), 8'(pos == 4 ? !par : par));
                par = 1'b0;
            end else begin
                check("sample", 8'(cap.skew_ref), 8'(cap.data[3 - pos % 5]));
                par = par ^ cap.data[3 - pos % 5];
            end
            check("timing_ref", 8'(cap.timing_ref), 8'((scnt / 8) % 2));
            // transitions seen inside the current ten-bit frame
            run = (pos == 0) ? 0 : run + int'(cap.skew_ref !== last_ref);
            last_ref = cap.skew_ref;
            if (pos == 9) begin
                check("ref_run", 8'(run > 0), 8'h01);
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        ser_clk = 1'b0;
        ser_data = 1'b0;
        sig_lost = 1'b0;
        inv_en = 1'b0;
        void'($urandom(9));
        cycles(1);
        check("reset_out", pins, 8'h00);
        cycles(1);
        rst_n = 1'b1;
        cycles(2);
        check("alarm_init", 8'(alarm_status), 8'h01);
        send_rand(24);
        drain();
        // clock loss keeps lanes zero, reference lane running
        wait_alarm(1'b1, 300);
        cycles(90);
        wait_cap();
        inv_en = 1'b1;
        fork
            send_rand(24);
            wait_alarm(1'b0, 300);
        join
        drain();
        wait_alarm(1'b1, 300);
        // long enough for alarm slots in every frame position
        cycles(400);
        wait_cap();
        inv_en = 1'b0;
        // loss of input signal while the bit clock still runs
        fork
            send_rand(8);
            begin
                cycles(100);
                wait_cap();
                sig_lost = 1'b1;
                wait_alarm(1'b1, 50);
            end
        join
        exp_q.delete();
        cycles(150);
        sig_lost = 1'b0;
        fork
            send_rand(16);
            wait_alarm(1'b0, 300);
        join
        drain();
        finish_test();
    end
endmodule
